//--- hw/bcc_pkg.sv
package bcc_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [3:0] A_SEC1  = 4'h0;
	localparam logic [3:0] A_SEC10 = 4'h1;
	localparam logic [3:0] A_MIN1  = 4'h2;
	localparam logic [3:0] A_MIN10 = 4'h3;
	localparam logic [3:0] A_HR1   = 4'h4;
	localparam logic [3:0] A_HR10  = 4'h5;
	localparam logic [3:0] A_DAY1  = 4'h6;
	localparam logic [3:0] A_DAY10 = 4'h7;
	localparam logic [3:0] A_MON1  = 4'h8;
	localparam logic [3:0] A_MON10 = 4'h9;
	localparam logic [3:0] A_YR1   = 4'ha;
	localparam logic [3:0] A_YR10  = 4'hb;
	localparam logic [3:0] A_WEEK  = 4'hc;
	localparam logic [3:0] A_CTL_D = 4'hd;
	localparam logic [3:0] A_CTL_E = 4'he;
	localparam logic [3:0] A_CTL_F = 4'hf;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int D_HOLD = 0;
	localparam int D_IRQ  = 2;
	localparam int D_ADJ  = 3;
	localparam int F_REST = 0;
	localparam int F_STOP = 1;
	localparam int F_24H  = 2;
	localparam int H_PM   = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] CE_RST = 4'h0;
	localparam logic [2:0] CF_RST = 3'h4;
	localparam logic [3:0] DIGIT_ONE = 4'h1;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ       = 200;
	localparam real         STD_PULSE_MS  = 7.8125;
	localparam int unsigned STD_PULSE_CYC = int'(STD_PULSE_MS * 1000.0 * CLK_MHZ);
	localparam int unsigned ADJ_US        = 125;
	localparam int unsigned ADJ_ROUND_CYC = ADJ_US * CLK_MHZ;
	localparam int          CNT_W         = 21;
	localparam int          PRE_W         = 15;
	localparam int          SUB_W         = 9;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       t1;
		logic       t0;
		logic       pulse_mode_select;
		logic       mask;
	} bcc_ctl_e_t;

	typedef struct packed {
		logic       xt;
		logic       ale;
		logic       sel_n;
		logic       pvs;
		logic       rd_n;
		logic       wr_n;
		logic [3:0] addr;
		logic [3:0] data;
	} bcc_pins_t;

	localparam bcc_pins_t PINS_RST = '{xt: 1'b0, ale: 1'b0, sel_n: 1'b1, pvs: 1'b0,
		rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, data: 4'h0};

endpackage : bcc_pkg

//--- hw/bcc_top.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Contract
// RULE1 - Data port is four bits, bit 0 least significant.
// RULE2 - Address passes while strobe high and select low, held after.
// RULE3 - Write stores data on write strobe rising edge when selected.
// RULE4 - Read drives addressed register while selected and read low.
// RULE5 - Read and write low together: no drive.
// RULE6 - Selects gate strobes; power valid independent of latch strobe.
// RULE7 - Timing pulse is open drain, active low, ignores selects.
// RULE8 - Counter digits hold positive BCD.
// RULE9 - 24h: afternoon flag ignored, reads 0; 12h bit2 as written.
// RULE10 - Leap years from two-digit year give February 29 days.
// RULE11 - Nonexistent day becomes day one of next month at day carry.
// RULE12 - Weekday counts 0 to 6 and wraps.
// RULE13 - Count freeze blocks one-second increment of unit seconds.
// RULE14 - Host touches counters only when busy reads 0 under freeze.
// RULE15 - Carry during freeze applied after freeze clears.
// RULE16 - Power valid select low forces count freeze to 0.
// RULE17 - Control D bit 1 is read-only busy.
// RULE18 - Pending flag reads 1 exactly while pulse output is low.
// RULE19 - Interrupt mode: low until flag written 0; new events dropped.
// RULE20 - Standard mode: low until cleared or 7.8125 ms elapse.
// RULE21 - Host writes 1 to pending flag when changing other D bits.
// RULE22 - Rounding bit self-clears after 125 us.
// RULE23 - Pending flag cleared only by writing 0; set only by logic. Code also clears it at standard pulse end and while mask is set.
// RULE24 - Unimplemented bits ignore writes, read 0.
// RULE25 - Counters at 0 to C, control at D to F.
// ----------------------------------------------------------------
module bcc_top
	import bcc_pkg::*;
#(
	parameter int unsigned PULSE_CYC = STD_PULSE_CYC,
	parameter int unsigned ADJ_CYC   = ADJ_ROUND_CYC
) (
	input  wire logic       clock_i,
	input  wire logic       nrst_i,
	input  wire logic       clk_en_i,
	input  wire logic       xt_i,
	input  wire logic [3:0] addr_i,
	input  wire logic       latch_strobe_i,
	input  wire logic       primary_select_n_i,
	input  wire logic       power_valid_select_i,
	input  wire logic       rd_n_i,
	input  wire logic       wr_n_i,
	input  wire logic [3:0] data_i,
	output logic      [3:0] data_o,
	output logic            data_oe_o,
	output logic            timing_pulse_out_o,
	output logic            timing_pulse_out_oe_o
);

	bcc_pins_t        pins, p1_q, p2_q;
	logic             xt_prev_q, wr_prev_q;
	logic [3:0]       addr_q, addr, wd, rd_val;
	logic             sel, wr_evt, rd_on;
	logic [3:0]       sec1_q, min1_q, hr1_q, day1_q, mon1_q, yr1_q, yr10_q;
	logic [2:0]       sec10_q, min10_q, hr10_q, week_q;
	logic [1:0]       day10_q;
	logic             mon10_q;
	logic             hold_q, adj_q, busy_q, irq_q, irq_d, pend_q;
	bcc_ctl_e_t       e_q;
	logic [2:0]       f_q;
	logic [PRE_W-1:0] pre_q;
	logic [CNT_W-1:0] adj_cnt_q, pcnt_q;
	logic             xt_rise, tick64, tick1, adj_done, adj_up, sec_step;
	logic             c_min, c_hr, c_day, c_mon, c_yr, h24, leap, ev, pulse_end, clr_wr;
	logic [5:0]       last_day;

	// BCD digit step, wraps past nine
	function automatic logic [3:0] inc4(input logic [3:0] v);
		inc4 = (v >= 4'h9) ? 4'h0 : v + 4'h1;
	endfunction : inc4

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	assign pins = '{xt: xt_i, ale: latch_strobe_i, sel_n: primary_select_n_i, pvs: power_valid_select_i,
		rd_n: rd_n_i, wr_n: wr_n_i, addr: addr_i, data: data_i};

	// Two stages; edge detectors look only at the second
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			p1_q      <= PINS_RST;
			p2_q      <= PINS_RST;
			xt_prev_q <= 1'b0;
			wr_prev_q <= 1'b1;
		end else if (clk_en_i) begin
			p1_q      <= pins;
			p2_q      <= p1_q;
			xt_prev_q <= p2_q.xt;
			wr_prev_q <= p2_q.wr_n;
		end
	end

	// ----------------------------------------------------------------
	// Host bus decode
	// ----------------------------------------------------------------
	assign sel    = p2_q.pvs & ~p2_q.sel_n;                           // [RULE6]
	assign addr   = (p2_q.ale & ~p2_q.sel_n) ? p2_q.addr : addr_q;    // [RULE2]
	assign wd     = p2_q.data;                                        // [RULE1]
	assign wr_evt = clk_en_i & sel & ~wr_prev_q & p2_q.wr_n;          // [RULE3]
	assign rd_on  = sel & ~p2_q.rd_n & p2_q.wr_n;                     // [RULE4] [RULE5]
	assign clr_wr = wr_evt & (addr == A_CTL_D) & ~wd[D_IRQ];          // [RULE23]
	assign h24    = f_q[F_24H];

	// Address latch, transparent while strobe high and select low
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			addr_q <= 4'h0;
		end else if (clk_en_i && p2_q.ale && !p2_q.sel_n) begin
			addr_q <= p2_q.addr;                                      // [RULE2]
		end
	end

	// Read mux; missing bits read as zero
	always_comb begin
		unique case (addr)                                            // [RULE25]
			A_SEC1:  rd_val = sec1_q;
			A_SEC10: rd_val = {1'b0, sec10_q};                        // [RULE24]
			A_MIN1:  rd_val = min1_q;
			A_MIN10: rd_val = {1'b0, min10_q};
			A_HR1:   rd_val = hr1_q;
			A_HR10:  rd_val = {1'b0, hr10_q[H_PM] & ~h24, hr10_q[1:0]}; // [RULE9]
			A_DAY1:  rd_val = day1_q;
			A_DAY10: rd_val = {2'b00, day10_q};
			A_MON1:  rd_val = mon1_q;
			A_MON10: rd_val = {3'b000, mon10_q};
			A_YR1:   rd_val = yr1_q;
			A_YR10:  rd_val = yr10_q;
			A_WEEK:  rd_val = {1'b0, week_q};
			A_CTL_D: rd_val = {adj_q, irq_q, busy_q, hold_q};         // [RULE17] [RULE18]
			A_CTL_E: rd_val = e_q;
			A_CTL_F: rd_val = {1'b0, f_q};
		endcase
	end

	// Registered data drive; a clash of strobes keeps the port off
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			data_o    <= 4'h0;
			data_oe_o <= 1'b0;
		end else if (clk_en_i) begin
			data_o    <= rd_val;
			data_oe_o <= rd_on;                                       // [RULE4] [RULE5]
		end
	end

	// ----------------------------------------------------------------
	// Control registers D, E, F
	// ----------------------------------------------------------------
	assign adj_done = adj_q && (adj_cnt_q == CNT_W'(ADJ_CYC - 1));
	assign adj_up   = adj_done && (sec10_q >= 3'h3);

	// Freeze, rounding, mode bits
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			hold_q    <= 1'b0;
			adj_q     <= 1'b0;
			adj_cnt_q <= '0;
			e_q       <= CE_RST;
			f_q       <= CF_RST;
		end else if (clk_en_i) begin
			adj_cnt_q <= adj_q ? adj_cnt_q + 1'b1 : '0;
			if (adj_done) begin
				adj_q     <= 1'b0;                                    // [RULE22]
				adj_cnt_q <= '0;
			end
			if (wr_evt && addr == A_CTL_D) begin
				hold_q <= wd[D_HOLD];                                 // [RULE13]
				if (wd[D_ADJ]) adj_q <= 1'b1;                         // [RULE22]
			end
			if (wr_evt && addr == A_CTL_E) e_q <= wd;
			if (wr_evt && addr == A_CTL_F) begin
				f_q[F_REST] <= wd[F_REST];
				f_q[F_STOP] <= wd[F_STOP];
				// Hour mode only changes while the divider is in reset
				if (f_q[F_REST]) f_q[F_24H] <= wd[F_24H];
			end
			if (!p2_q.pvs) hold_q <= 1'b0;                            // [RULE16]
		end
	end

	// ----------------------------------------------------------------
	// Time base from the crystal
	// ----------------------------------------------------------------
	assign xt_rise = p2_q.xt & ~xt_prev_q;
	assign tick64  = xt_rise & ~f_q[F_STOP] & ~f_q[F_REST] & (&pre_q[SUB_W-1:0]);
	assign tick1   = tick64 & (&pre_q);
	assign sec_step = pend_q & ~hold_q & ~wr_evt & ~adj_done;         // [RULE13]

	// Divider, busy window and retained second carry
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			pre_q  <= '0;
			pend_q <= 1'b0;
			busy_q <= 1'b0;
		end else if (clk_en_i) begin
			if (f_q[F_REST]) pre_q <= '0;
			else if (xt_rise && !f_q[F_STOP]) pre_q <= pre_q + 1'b1;
			pend_q <= tick1 | (pend_q & ~sec_step);                   // [RULE15]
			busy_q <= pend_q | (&pre_q) | adj_q;                      // [RULE17] [RULE14]
		end
	end

	// ----------------------------------------------------------------
	// Calendar chain
	// ----------------------------------------------------------------
	always_comb begin
		leap = yr10_q[0] ? (yr1_q == 4'h2 || yr1_q == 4'h6)           // [RULE10]
			: (yr1_q == 4'h0 || yr1_q == 4'h4 || yr1_q == 4'h8);
		unique case ({mon10_q, mon1_q})
			5'h02:                      last_day = leap ? 6'h29 : 6'h28;
			5'h04, 5'h06, 5'h09, 5'h11: last_day = 6'h30;
			default:                    last_day = 6'h31;
		endcase
		c_min = (sec_step && sec10_q == 3'h5 && sec1_q == 4'h9) || adj_up;
		c_hr  = c_min && min10_q == 3'h5 && min1_q == 4'h9;
		c_day = c_hr && (h24 ? (hr10_q[1] && hr1_q == 4'h3)
			: (hr10_q[H_PM] && hr10_q[0] && hr1_q == 4'h1));
		// Greater-or-equal also catches a day that does not exist
		c_mon = c_day && ({day10_q, day1_q} >= last_day);             // [RULE11]
		c_yr  = c_mon && mon10_q && mon1_q == 4'h2;
	end

	// Digits; a host write wins over counting in that cycle
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			{sec1_q, sec10_q, min1_q, min10_q, hr1_q, hr10_q} <= '0;
			{day10_q, mon10_q, yr1_q, yr10_q, week_q}          <= '0;
			day1_q <= DIGIT_ONE;
			mon1_q <= DIGIT_ONE;
		end else if (clk_en_i) begin
			if (wr_evt) begin
				case (addr)                                           // [RULE3] [RULE8] [RULE24]
					A_SEC1:  sec1_q  <= wd;
					A_SEC10: sec10_q <= wd[2:0];
					A_MIN1:  min1_q  <= wd;
					A_MIN10: min10_q <= wd[2:0];
					A_HR1:   hr1_q   <= wd;
					A_HR10:  hr10_q  <= {wd[H_PM] & ~h24, wd[1:0]};   // [RULE9]
					A_DAY1:  day1_q  <= wd;
					A_DAY10: day10_q <= wd[1:0];
					A_MON1:  mon1_q  <= wd;
					A_MON10: mon10_q <= wd[0];
					A_YR1:   yr1_q   <= wd;
					A_YR10:  yr10_q  <= wd;
					A_WEEK:  week_q  <= wd[2:0];
					default: ;
				endcase
			end else begin
				if (adj_done) begin
					sec1_q  <= 4'h0;
					sec10_q <= 3'h0;
				end else if (sec_step) begin                          // [RULE8]
					sec1_q <= inc4(sec1_q);
					if (sec1_q == 4'h9) sec10_q <= (sec10_q == 3'h5) ? 3'h0 : sec10_q + 3'h1;
				end
				if (c_min) begin
					min1_q <= inc4(min1_q);
					if (min1_q == 4'h9) min10_q <= (min10_q == 3'h5) ? 3'h0 : min10_q + 3'h1;
				end
				if (c_hr && h24) begin
					if (hr10_q[1] && hr1_q == 4'h3) begin
						hr1_q       <= 4'h0;
						hr10_q[1:0] <= 2'h0;
					end else begin
						hr1_q <= inc4(hr1_q);
						if (hr1_q == 4'h9) hr10_q[1:0] <= hr10_q[1:0] + 2'h1;
					end
				end else if (c_hr) begin
					// Twelve-hour face runs 12, 1 .. 11; flag flips at 11 to 12
					if (hr10_q[0] && hr1_q == 4'h2) begin
						hr1_q     <= DIGIT_ONE;
						hr10_q[0] <= 1'b0;
					end else if (hr10_q[0] && hr1_q == 4'h1) begin
						hr1_q        <= 4'h2;
						hr10_q[H_PM] <= ~hr10_q[H_PM];
					end else begin
						hr1_q <= inc4(hr1_q);
						if (hr1_q == 4'h9) hr10_q[0] <= 1'b1;
					end
				end
				if (c_day) begin
					week_q <= (week_q >= 3'h6) ? 3'h0 : week_q + 3'h1; // [RULE12]
					if (c_mon) begin
						day1_q  <= DIGIT_ONE;                         // [RULE11]
						day10_q <= 2'h0;
					end else begin
						day1_q <= inc4(day1_q);
						if (day1_q == 4'h9) day10_q <= day10_q + 2'h1;
					end
				end
				if (c_mon) begin
					if (c_yr) begin
						mon1_q  <= DIGIT_ONE;
						mon10_q <= 1'b0;
					end else if (mon1_q == 4'h9) begin
						mon1_q  <= 4'h0;
						mon10_q <= 1'b1;
					end else begin
						mon1_q <= mon1_q + 4'h1;
					end
				end
				if (c_yr) begin
					yr1_q <= inc4(yr1_q);
					if (yr1_q == 4'h9) yr10_q <= inc4(yr10_q);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Timing pulse and pending flag
	// ----------------------------------------------------------------
	always_comb begin
		unique case ({e_q.t1, e_q.t0})
			2'b00: ev = tick64;
			2'b01: ev = sec_step;
			2'b10: ev = c_min;
			2'b11: ev = c_hr;
		endcase
		pulse_end = ~e_q.pulse_mode_select & irq_q & (pcnt_q == CNT_W'(PULSE_CYC - 1)); // [RULE20]
		irq_d = irq_q;
		if (clr_wr || pulse_end) irq_d = 1'b0;                        // [RULE23] [RULE20]
		if (ev) irq_d = 1'b1;                                         // [RULE19]
		if (e_q.mask) irq_d = 1'b0;
	end

	// Flag and pin share one next value, so they never disagree
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			irq_q                 <= 1'b0;
			pcnt_q                <= '0;
			timing_pulse_out_o    <= 1'b0;
			timing_pulse_out_oe_o <= 1'b0;
		end else if (clk_en_i) begin
			irq_q                 <= irq_d;
			pcnt_q                <= (irq_d && irq_q && !pulse_end && !clr_wr) ? pcnt_q + 1'b1 : '0;
			timing_pulse_out_o    <= 1'b0;                            // [RULE7]
			timing_pulse_out_oe_o <= irq_d;                           // [RULE18]
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	sequence s_read_req;
		clk_en_i && sel && !p2_q.rd_n && p2_q.wr_n;
	endsequence
	sequence s_adj_start;
		clk_en_i && wr_evt && addr == A_CTL_D && wd[D_ADJ];
	endsequence

	property p_read_drive;
		s_read_req |=> data_oe_o && data_o == $past(rd_val);
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read not driven"); // [RULE4]

	property p_clash;
		clk_en_i && !p2_q.rd_n && !p2_q.wr_n |=> !data_oe_o;
	endproperty
	a_clash: assert property (p_clash) else $error("drive during strobe clash"); // [RULE5]

	property p_freeze_off;
		clk_en_i && !p2_q.pvs |=> !hold_q;
	endproperty
	a_freeze_off: assert property (p_freeze_off) else $error("freeze kept without power valid"); // [RULE16]

	property p_flag_pin;
		irq_q == timing_pulse_out_oe_o && !timing_pulse_out_o;
	endproperty
	a_flag_pin: assert property (p_flag_pin) else $error("flag and pulse pin disagree"); // [RULE18]

	property p_hold_stops;
		clk_en_i && hold_q && !wr_evt && !adj_done |=> $stable(sec1_q);
	endproperty
	a_hold_stops: assert property (p_hold_stops) else $error("seconds moved while frozen"); // [RULE13]

	// Carry seen while frozen must leave the second pending next cycle
	property p_carry_kept;
		clk_en_i && tick1 && hold_q |=> pend_q;
	endproperty
	a_carry_kept: assert property (p_carry_kept) else $error("carry lost"); // [RULE15]

	property p_adj_cycle;
		s_adj_start |=> adj_q;
	endproperty
	a_adj_cycle: assert property (p_adj_cycle) else $error("rounding not started"); // [RULE22]

	property p_adj_end;
		clk_en_i && adj_done |=> !adj_q && sec1_q == 4'h0 && sec10_q == 3'h0;
	endproperty
	a_adj_end: assert property (p_adj_end) else $error("rounding did not finish"); // [RULE22]

	property p_week_range;
		week_q <= 3'h6 || $past(wr_evt);
	endproperty
	a_week_range: assert property (p_week_range) else $error("weekday out of range"); // [RULE12]

	property p_irq_sticky;
		clk_en_i && irq_q && e_q.pulse_mode_select && !e_q.mask && !clr_wr |=> irq_q;
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt flag dropped"); // [RULE19]

	property p_latch_hold;
		clk_en_i && !(p2_q.ale && !p2_q.sel_n) |=> $stable(addr_q);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("address latch moved"); // [RULE2]

endmodule : bcc_top

//--- testbench/bcc_host_model.sv
`timescale 1ns/100ps
// ------------------------------
// Host side of the register pins
// ------------------------------
module bcc_host_model (
	input  wire logic       clock_i,
	input  wire logic [3:0] data_i,
	input  wire logic       data_oe_i,
	output logic      [3:0] addr_o,
	output logic            strobe_o,
	output logic            sel_n_o,
	output logic            pvs_o,
	output logic            rd_n_o,
	output logic            wr_n_o,
	output logic      [3:0] wdata_o
);
	// Idle: deselected, strobes high, latch holds until selected
	initial begin
		addr_o = 4'h0;
		strobe_o = 1'b1;
		sel_n_o = 1'b1;
		pvs_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		wdata_o = 4'h0;
	end

	// Step just past the sampling edge
	task automatic edges(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : edges

	// Pins pass two sync flops, so each write strobe level is held four clocks
	task automatic bus_write(input logic [3:0] a, input logic [3:0] d);
		addr_o = a;
		wdata_o = d;
		sel_n_o = 1'b0;
		edges(3);
		wr_n_o = 1'b0;
		edges(4);
		wr_n_o = 1'b1;
		edges(4);
		sel_n_o = 1'b1;
		wdata_o = ~d; // Released bus must not keep the old value
		edges(2);
	endtask : bus_write

	// With both set the write strobe falls too, carrying d
	task automatic bus_read(input logic [3:0] a, input logic sel_n, input logic both,
		input logic [3:0] d, output logic [3:0] q, output logic oe);
		addr_o = a;
		wdata_o = d;
		sel_n_o = sel_n;
		edges(3);
		rd_n_o = 1'b0;
		wr_n_o = ~both;
		edges(5);
		q = data_i;
		oe = data_oe_i;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		edges(4);
		sel_n_o = 1'b1;
		wdata_o = ~d;
		edges(2);
	endtask : bus_read

	// Capture an address, then close the latch
	task automatic latch(input logic [3:0] a);
		addr_o = a;
		sel_n_o = 1'b0;
		edges(3);
		strobe_o = 1'b0;
		edges(3);
		sel_n_o = 1'b1;
	endtask : latch

	// Latch strobe and power valid levels
	task automatic set_ctl(input logic s, input logic p);
		strobe_o = s;
		pvs_o = p;
		edges(6);
	endtask : set_ctl
endmodule : bcc_host_model

//--- testbench/bcc_calendar_clock_bus_tb_top.sv
`timescale 1ns/100ps
// ------------------------------
// Bench top
// ------------------------------
module bcc_calendar_clock_bus_tb_top import bcc_pkg::*;;
	logic        clock, nrst, xt, xt_run, clk_en;
	logic [3:0]  addr, wdata, rdata, bus, q;
	logic        strobe, sel_n, pvs, rd_n, wr_n, oe, tp, tp_oe, qoe;
	int          bad_count, n_tests;
	logic [51:0] cases_in [4];
	logic [51:0] cases_out [4];

	// Wire level of the shared data pins
	assign bus = oe ? rdata : wdata;

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Crystal stands still unless a test needs the time base
	initial begin
		xt = 1'b0;
		forever #10 if (xt_run) xt = ~xt;
	end

	// Short pulse and rounding counts keep the run brief
	bcc_top #(.PULSE_CYC(20), .ADJ_CYC(10)) uut (.clock_i(clock), .nrst_i(nrst), .clk_en_i(clk_en),
		.xt_i(xt), .addr_i(addr), .latch_strobe_i(strobe), .primary_select_n_i(sel_n),
		.power_valid_select_i(pvs), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(bus), .data_o(rdata),
		.data_oe_o(oe), .timing_pulse_out_o(tp), .timing_pulse_out_oe_o(tp_oe));

	bcc_host_model host (.clock_i(clock), .data_i(bus), .data_oe_i(oe), .addr_o(addr), .strobe_o(strobe),
		.sel_n_o(sel_n), .pvs_o(pvs), .rd_n_o(rd_n), .wr_n_o(wr_n), .wdata_o(wdata));

	task automatic check(input string name, input logic [3:0] exp, input logic [3:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// Selected read; the drive must be on and masked bits match
	task automatic rd(input logic [3:0] a, input logic [3:0] m, input logic [3:0] exp, input string name);
		host.bus_read(a, 1'b0, 1'b0, 4'h0, q, qoe);
		check("read drive", 4'h1, {3'h0, qoe});
		check(name, exp, q & m);
	endtask : rd

	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run

	// A 1/64 tick is 2048 clocks here; bounded well above that
	task automatic wait_pulse;
		int i;
		i = 0;
		while (tp_oe !== 1'b1 && i < 3000) begin
			host.edges(1);
			i++;
		end
		if (i == 3000) begin
			bad_count++;
			$display("[FAIL] pulse expected 1 seen %b", tp_oe);
			complete_run();
		end
	endtask : wait_pulse

	initial begin
		nrst = 1'b0;
		clk_en = 1'b1;
		xt_run = 1'b0;
		bad_count = 0;
		n_tests = 0;
		// Digits from address 0 upward, week in the top nibble
		cases_in = '{52'h6840228235930, 52'h2850228235930, 52'h0851131235930, 52'h4850115235929};
		cases_out = '{52'h0840229000000, 52'h3850301000000, 52'h1851201000000, 52'h4850115235900};
		repeat (10) @(posedge clock);
		#1;
		nrst = 1'b1;
		host.edges(4);
		for (int a = 0; a < 16; a++) begin
			rd(a[3:0], 4'hf, (a == 6 || a == 8) ? 4'h1 : ((a == 15) ? 4'h4 : 4'h0), "reset value");
		end
		// Clock enable low freezes the synchronisers, so the write is never seen
		clk_en = 1'b0;
		host.bus_write(A_WEEK, 4'h3);
		clk_en = 1'b1;
		host.edges(2);
		rd(A_WEEK, 4'hf, 4'h0, "write while disabled");
		host.bus_write(A_MIN10, 4'h8);
		rd(A_MIN10, 4'hf, 4'h0, "min10 bit3");
		host.bus_write(A_HR10, 4'h6);
		rd(A_HR10, 4'hf, 4'h2, "hr10 in 24h");
		host.bus_write(A_DAY10, 4'hc);
		rd(A_DAY10, 4'hf, 4'h0, "day10 upper bits");
		host.bus_write(A_CTL_D, 4'h2);
		rd(A_CTL_D, 4'hf, 4'h0, "busy write");
		// Reads that must leave the data pins undriven
		host.bus_read(A_MON1, 1'b1, 1'b0, 4'h0, q, qoe);
		check("deselected drive", 4'h0, {3'h0, qoe});
		host.bus_read(A_YR1, 1'b0, 1'b1, 4'h5, q, qoe);
		check("read and write drive", 4'h0, {3'h0, qoe});
		host.set_ctl(1'b1, 1'b0);
		host.bus_read(A_MON1, 1'b0, 1'b0, 4'h0, q, qoe);
		check("power invalid drive", 4'h0, {3'h0, qoe});
		host.set_ctl(1'b1, 1'b1);
		// Freeze dropped by a power valid low spell
		host.bus_write(A_CTL_D, 4'h5);
		rd(A_CTL_D, 4'hf, 4'h1, "freeze set");
		host.set_ctl(1'b1, 1'b0);
		host.set_ctl(1'b1, 1'b1);
		rd(A_CTL_D, 4'h1, 4'h0, "freeze forced off");
		host.latch(A_MON1);
		rd(A_YR1, 4'hf, 4'h1, "latched address");
		host.set_ctl(1'b1, 1'b1);
		// Half-minute rounding rippling through the calendar
		for (int c = 0; c < 4; c++) begin
			host.bus_write(A_CTL_D, 4'h5);
			rd(A_CTL_D, 4'h3, 4'h1, "frozen and not busy");
			for (int a = 0; a < 13; a++) host.bus_write(a[3:0], cases_in[c][4*a +: 4]);
			host.bus_write(A_CTL_D, 4'h4);
			host.bus_write(A_CTL_D, 4'hc);
			host.edges(20);
			rd(A_CTL_D, 4'hb, 4'h0, "rounding bit cleared");
			for (int a = 0; a < 13; a++) rd(a[3:0], 4'hf, cases_out[c][4*a +: 4], "rounded digit");
		end
		// Standard pulse, then interrupt mode
		xt_run = 1'b1;
		wait_pulse();
		check("pulse pin level", 4'h0, {3'h0, tp});
		host.edges(10);
		check("standard pulse held", 4'h1, {3'h0, tp_oe});
		host.edges(15);
		check("standard pulse ended", 4'h0, {3'h0, tp_oe});
		host.bus_write(A_CTL_E, 4'h2);
		host.bus_write(A_CTL_D, 4'h0);
		wait_pulse();
		host.edges(40);
		check("interrupt held", 4'h1, {3'h0, tp_oe});
		rd(A_CTL_D, 4'h4, 4'h4, "pending flag set");
		host.bus_write(A_CTL_D, 4'h4);
		check("flag after write 1", 4'h1, {3'h0, tp_oe});
		host.bus_write(A_CTL_D, 4'h0);
		check("flag after write 0", 4'h0, {3'h0, tp_oe});
		rd(A_CTL_D, 4'h4, 4'h0, "pending flag clear");
		xt_run = 1'b0;
		complete_run();
	end
endmodule : bcc_calendar_clock_bus_tb_top
